/* File: src/sdc_pkg.sv */
package sdc_pkg;
   // ==========================================================
   // register map
   localparam logic [1:0] SDC_ADDR_CTRL = 2'h0;
   localparam int SDC_ADDR_W = 2;
   localparam logic [7:0] SDC_CTRL_RESET = 8'h00;
   localparam logic [31:0] SDC_RD_UNMAPPED = 32'h0000_0000;
   // ==========================================================
   // control register fields
   localparam int SDC_BIT_ITG = 7;
   localparam int SDC_BIT_DRIVE = 6;
   localparam int SDC_BIT_RECIRC = 5;
   localparam int SDC_BIT_POL = 4;
   localparam int SDC_BIT_MOTOR = 2;
   localparam int SDC_STEP_HI = 1;
   localparam int SDC_STEP_LO = 0;
   localparam logic [7:0] SDC_CTRL_MASK = 8'hf7;
   localparam logic [1:0] SDC_STEP_EAST = 2'h0;
   localparam logic [1:0] SDC_STEP_NORTH = 2'h1;
   localparam logic [1:0] SDC_STEP_WEST = 2'h2;
   localparam logic [1:0] SDC_STEP_SOUTH = 2'h3;
   // ==========================================================
   // coil current codes: zero, +imax, -imax
   typedef enum logic [2:0] {
      SDC_I_ZERO = 3'b001,
      SDC_I_POS = 3'b010,
      SDC_I_NEG = 3'b100
   } sdc_cur_t;
   // bridge vector bit 0 is transistor 1; switch vector bit 0 is switch 1
   localparam logic [7:0] SDC_ALL_OFF = 8'h00;
endpackage

/* File: src/sdc_cfg_if.sv */
`timescale 1ns/1ns
// decoded control settings shared between register file and decoder
interface sdc_cfg_if;
   logic integrate_select;
   logic drive;
   logic recirc;
   logic integration_polarity;
   logic [1:0] step;
   modport src (output integrate_select, output drive, output recirc, output integration_polarity, output step);
   modport dst (input integrate_select, input drive, input recirc, input integration_polarity, input step);
endinterface

/* File: src/sdc_decode.sv */
`timescale 1ns/1ns
// ==========================================================
// combinational bridge and routing switch decode
module sdc_decode
   import sdc_pkg::*;
(
   sdc_cfg_if.dst cfg,
   output logic [7:0] o_bridge,
   output logic [7:0] o_switch,
   output sdc_cur_t o_sin_cur,
   output sdc_cur_t o_cos_cur
);
   // drive pair for the coil selected by the step
   function automatic logic [7:0] drive_pair(input logic [1:0] s);
      case (s)
         SDC_STEP_EAST: drive_pair = 8'h09;  // t1 t4
         SDC_STEP_NORTH: drive_pair = 8'h90; // t5 t8
         SDC_STEP_WEST: drive_pair = 8'h06;  // t2 t3
         default: drive_pair = 8'h60;        // t6 t7
      endcase
   endfunction

   // ==========================================================
   // transistors
   always_comb begin
      o_bridge = SDC_ALL_OFF;
      if (cfg.drive) begin
         o_bridge = drive_pair(cfg.step);
      end
      // blanking recirculates the idle coil; integration leaves it floating
      if (!cfg.integrate_select) begin
         if (!cfg.step[0]) begin
            o_bridge = o_bridge | (cfg.recirc ? 8'ha0 : 8'h50);
         end else begin
            o_bridge = o_bridge | (cfg.recirc ? 8'h0a : 8'h05);
         end
      end
   end

   // ==========================================================
   // routing switches to converter
   always_comb begin
      o_switch = SDC_ALL_OFF;
      if (cfg.integrate_select) begin
         case ({cfg.step, cfg.integration_polarity})
            3'h0: o_switch = 8'h90; // s5 ref, s8 integ
            3'h1: o_switch = 8'h60;
            3'h2: o_switch = 8'h06;
            3'h3: o_switch = 8'h09;
            3'h4: o_switch = 8'h60;
            3'h5: o_switch = 8'h90;
            3'h6: o_switch = 8'h09;
            default: o_switch = 8'h06;
         endcase
      end
   end

   // ==========================================================
   // coil current status
   always_comb begin
      o_sin_cur = SDC_I_ZERO;
      o_cos_cur = SDC_I_ZERO;
      if (cfg.drive) begin
         case (cfg.step)
            SDC_STEP_EAST: o_sin_cur = SDC_I_POS;
            SDC_STEP_WEST: o_sin_cur = SDC_I_NEG;
            SDC_STEP_NORTH: o_cos_cur = SDC_I_POS;
            default: o_cos_cur = SDC_I_NEG;
         endcase
      end
   end
endmodule

/* File: src/sdc_regs.sv */
`timescale 1ns/1ns
// ==========================================================
// avalon slave holding the control register
module sdc_regs
   import sdc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [SDC_ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic [7:0] o_ctrl,
   sdc_cfg_if.src cfg
);
   logic ack_q;
   logic wait_q;
   logic [7:0] ctrl_q;
   logic [31:0] rdata_q;
   logic hit;

   assign hit = (i_address == SDC_ADDR_CTRL);

   // one wait cycle per access; ack drops waitrequest on the first edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (i_read | i_write) & ~ack_q;
      end
   end

   // waitrequest has its own flop so the pin never sees a gate; always the inverse of ack
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~((i_read | i_write) & ~ack_q);
      end
   end

   // control register, writable any time
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_q <= SDC_CTRL_RESET;
      end else if (i_write && !ack_q && hit && i_byteenable[0]) begin
         ctrl_q <= i_writedata[7:0] & SDC_CTRL_MASK;
      end
   end

   // read data registered; unmapped reads return zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_q <= SDC_RD_UNMAPPED;
      end else if (i_read && !ack_q) begin
         rdata_q <= hit ? {24'h000000, ctrl_q} : SDC_RD_UNMAPPED;
      end
   end

   assign o_readdata = rdata_q;
   assign o_waitrequest = wait_q;
   assign o_ctrl = ctrl_q;
   assign cfg.integrate_select = ctrl_q[SDC_BIT_ITG];
   assign cfg.drive = ctrl_q[SDC_BIT_DRIVE];
   assign cfg.recirc = ctrl_q[SDC_BIT_RECIRC];
   assign cfg.integration_polarity = ctrl_q[SDC_BIT_POL];
   assign cfg.step = ctrl_q[SDC_STEP_HI:SDC_STEP_LO];

   // ==========================================================
   // checks
   property p_reg_reset;
      @(posedge i_clk) !i_rst_n |=> ctrl_q == SDC_CTRL_RESET;
   endproperty
   a_reg_reset: assert property (p_reg_reset) else $error("ctrl not cleared");

   property p_reg_write;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_write && !ack_q && hit && i_byteenable[0]
         |=> ctrl_q == ($past(i_writedata[7:0]) & SDC_CTRL_MASK);
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("write lost");

   property p_reg_ack;
      @(posedge i_clk) disable iff (!i_rst_n)
         (i_read || i_write) && !ack_q |=> !o_waitrequest;
   endproperty
   a_reg_ack: assert property (p_reg_ack) else $error("no ack");

   c_reg_wr: cover property (@(posedge i_clk) i_write && !o_waitrequest);
   c_reg_rd: cover property (@(posedge i_clk) i_read && !o_waitrequest);
endmodule

/* File: src/sdc_top.sv */
`timescale 1ns/1ns
// Behaviour
// - bit7 set floats idle coil, clear recirculates
// - itg clear: blanking, converter reset, accumulator zero
// - itg set routes idle coil to converter
// - bit6 drives or releases the stepped coil
// - bit5 picks high or low recirculation side
// - bit4 picks idle coil end to integrator
// - bit2 selects motor a or b
// - bits1:0 full step east north west south
// - itg set, drive clear: all transistors off
// - drive pairs t1t4 t5t8 t2t3 t6t7
// - blanking recirculation pairs per step and side
// - integration keeps idle coil transistors off
// - switch closure table by step and polarity
// - polarity swaps integrator and reference nodes
// - coil current signs per step
// - control register offset zero, any-time access
// - enable clear releases coils
module sdc_top
   import sdc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [SDC_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic i_return_zero_enable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [7:0] o_bridge_a,
   output logic [7:0] o_bridge_b,
   output logic o_coil_ctrl_a,
   output logic o_coil_ctrl_b,
   output logic [7:0] o_switch,
   output logic o_motor_select,
   output logic o_conv_reset,
   output logic o_acc_clear,
   output logic [2:0] o_sin_current,
   output logic [2:0] o_cos_current
);
   sdc_cfg_if cfg ();
   logic [7:0] ctrl;
   logic [7:0] bridge;
   logic [7:0] sw;
   sdc_cur_t sin_cur;
   sdc_cur_t cos_cur;
   logic [7:0] bridge_a_q;
   logic [7:0] bridge_b_q;
   logic own_a_q;
   logic own_b_q;
   logic [7:0] switch_q;
   logic motor_q;
   logic conv_rst_q;
   logic [2:0] sin_q;
   logic [2:0] cos_q;

   // ==========================================================
   // register slave
   sdc_regs u_regs (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_address(i_avs_address),
      .i_read(i_avs_read),
      .i_write(i_avs_write),
      .i_writedata(i_avs_writedata),
      .i_byteenable(i_avs_byteenable),
      .o_readdata(o_avs_readdata),
      .o_waitrequest(o_avs_waitrequest),
      .o_ctrl(ctrl),
      .cfg(cfg)
   );

   sdc_decode u_dec (
      .cfg(cfg),
      .o_bridge(bridge),
      .o_switch(sw),
      .o_sin_cur(sin_cur),
      .o_cos_cur(cos_cur)
   );

   // ==========================================================
   // bridge outputs go only to the selected motor and only while enabled;
   // registered so outputs lag the register by one clock
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         bridge_a_q <= SDC_ALL_OFF;
         bridge_b_q <= SDC_ALL_OFF;
         own_a_q <= 1'b0;
         own_b_q <= 1'b0;
      end else begin
         own_a_q <= i_return_zero_enable & ~ctrl[SDC_BIT_MOTOR];
         own_b_q <= i_return_zero_enable & ctrl[SDC_BIT_MOTOR];
         bridge_a_q <= (i_return_zero_enable && !ctrl[SDC_BIT_MOTOR]) ? bridge
            : SDC_ALL_OFF;
         bridge_b_q <= (i_return_zero_enable && ctrl[SDC_BIT_MOTOR]) ? bridge
            : SDC_ALL_OFF;
      end
   end

   // switches and converter control follow itg regardless of enable
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         switch_q <= SDC_ALL_OFF;
         motor_q <= 1'b0;
         conv_rst_q <= 1'b1;
         sin_q <= SDC_I_ZERO;
         cos_q <= SDC_I_ZERO;
      end else begin
         switch_q <= sw;
         motor_q <= ctrl[SDC_BIT_MOTOR];
         conv_rst_q <= ~ctrl[SDC_BIT_ITG];
         sin_q <= (i_return_zero_enable) ? sin_cur : SDC_I_ZERO;
         cos_q <= (i_return_zero_enable) ? cos_cur : SDC_I_ZERO;
      end
   end

   assign o_bridge_a = bridge_a_q;
   assign o_bridge_b = bridge_b_q;
   assign o_coil_ctrl_a = own_a_q;
   assign o_coil_ctrl_b = own_b_q;
   assign o_switch = switch_q;
   assign o_motor_select = motor_q;
   assign o_conv_reset = conv_rst_q;
   assign o_acc_clear = conv_rst_q;
   assign o_sin_current = sin_q;
   assign o_cos_current = cos_q;

   // ==========================================================
   // checks
   // field views for the checks; the motor split mirrors the bridge gating
   logic [1:0] chk_step;
   logic chk_itg;
   logic chk_drv;
   logic chk_a;
   logic chk_b;
   assign chk_step = ctrl[SDC_STEP_HI:SDC_STEP_LO];
   assign chk_itg = ctrl[SDC_BIT_ITG];
   assign chk_drv = ctrl[SDC_BIT_DRIVE];
   assign chk_a = i_return_zero_enable & ~ctrl[SDC_BIT_MOTOR];
   assign chk_b = i_return_zero_enable & ctrl[SDC_BIT_MOTOR];

   property p_itg_off;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_return_zero_enable && ctrl[SDC_BIT_ITG] && !ctrl[SDC_BIT_DRIVE]
         |=> (o_bridge_a | o_bridge_b) == SDC_ALL_OFF;
   endproperty
   a_itg_off: assert property (p_itg_off) else $error("bridge on in float");

   property p_release;
      @(posedge i_clk) disable iff (!i_rst_n)
         !i_return_zero_enable |=> (o_bridge_a | o_bridge_b) == SDC_ALL_OFF && !o_coil_ctrl_a;
   endproperty
   a_release: assert property (p_release) else $error("coils not released");

   property p_blank;
      @(posedge i_clk) disable iff (!i_rst_n)
         !ctrl[SDC_BIT_ITG] |=> o_switch == SDC_ALL_OFF && o_conv_reset && o_acc_clear;
   endproperty
   a_blank: assert property (p_blank) else $error("blanking not applied");

   property p_route;
      @(posedge i_clk) disable iff (!i_rst_n)
         ctrl[SDC_BIT_ITG] |=> $countones(o_switch) == 2 && !o_conv_reset;
   endproperty
   a_route: assert property (p_route) else $error("routing wrong");

   property p_east;
      @(posedge i_clk) disable iff (!i_rst_n)
         ctrl[SDC_BIT_ITG] && ctrl[1:0] == SDC_STEP_EAST && !ctrl[SDC_BIT_POL]
         |=> o_switch == 8'h90;
   endproperty
   a_east: assert property (p_east) else $error("east switches wrong");

   property p_drive_a;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_return_zero_enable && !ctrl[SDC_BIT_MOTOR] && ctrl[SDC_BIT_DRIVE]
         && ctrl[1:0] == SDC_STEP_NORTH |=> o_bridge_a[7] && o_bridge_a[4] && o_bridge_b == 8'h00;
   endproperty
   a_drive_a: assert property (p_drive_a) else $error("north drive wrong");

   property p_recirc;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_return_zero_enable && !ctrl[SDC_BIT_MOTOR] && !ctrl[SDC_BIT_ITG]
         && !ctrl[SDC_BIT_DRIVE] && ctrl[1:0] == SDC_STEP_WEST && ctrl[SDC_BIT_RECIRC]
         |=> o_bridge_a == 8'ha0;
   endproperty
   a_recirc: assert property (p_recirc) else $error("recirc wrong");

   property p_current;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_return_zero_enable && ctrl[SDC_BIT_DRIVE] && ctrl[1:0] == SDC_STEP_SOUTH
         |=> o_cos_current == SDC_I_NEG && o_sin_current == SDC_I_ZERO;
   endproperty
   a_current: assert property (p_current) else $error("current wrong");

   property p_float_even;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && chk_itg && !chk_step[0]
         |=> o_bridge_a[7:4] == 4'h0;
   endproperty
   a_float_even: assert property (p_float_even) else $error("idle cosine driven");

   property p_float_odd;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && chk_itg && chk_step[0]
         |=> o_bridge_a[3:0] == 4'h0;
   endproperty
   a_float_odd: assert property (p_float_odd) else $error("idle sine driven");

   property p_float_b;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_b && chk_itg && !chk_step[0]
         |=> o_bridge_b[7:4] == 4'h0;
   endproperty
   a_float_b: assert property (p_float_b) else $error("idle coil b driven");

   property p_recirc_hi;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && !chk_itg && !ctrl[SDC_BIT_RECIRC] && !chk_step[0]
         |=> o_bridge_a[7:4] == 4'h5;
   endproperty
   a_recirc_hi: assert property (p_recirc_hi) else $error("high recirc wrong");

   property p_recirc_lo;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && !chk_itg && ctrl[SDC_BIT_RECIRC] && !chk_step[0]
         |=> o_bridge_a[7:4] == 4'ha;
   endproperty
   a_recirc_lo: assert property (p_recirc_lo) else $error("low recirc wrong");

   property p_recirc_odd_hi;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && !chk_itg && !ctrl[SDC_BIT_RECIRC] && chk_step[0]
         |=> o_bridge_a[3:0] == 4'h5;
   endproperty
   a_recirc_odd_hi: assert property (p_recirc_odd_hi) else $error("sine recirc wrong");

   property p_recirc_odd_lo;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && !chk_itg && ctrl[SDC_BIT_RECIRC] && chk_step[0]
         |=> o_bridge_a[3:0] == 4'ha;
   endproperty
   a_recirc_odd_lo: assert property (p_recirc_odd_lo) else $error("sine recirc wrong");

   property p_undriven;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && !chk_drv && !chk_step[0]
         |=> o_bridge_a[3:0] == 4'h0;
   endproperty
   a_undriven: assert property (p_undriven) else $error("sine not released");

   property p_undriven_odd;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && !chk_drv && chk_step[0]
         |=> o_bridge_a[7:4] == 4'h0;
   endproperty
   a_undriven_odd: assert property (p_undriven_odd) else $error("cosine not released");

   property p_drive_east;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && chk_drv && chk_step == SDC_STEP_EAST
         |=> o_bridge_a[3:0] == 4'h9;
   endproperty
   a_drive_east: assert property (p_drive_east) else $error("east drive wrong");

   property p_drive_west;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a && chk_drv && chk_step == SDC_STEP_WEST
         |=> o_bridge_a[3:0] == 4'h6;
   endproperty
   a_drive_west: assert property (p_drive_west) else $error("west drive wrong");

   property p_drive_south;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_b && chk_drv && chk_step == SDC_STEP_SOUTH
         |=> o_bridge_b[7:4] == 4'h6 && o_bridge_a == SDC_ALL_OFF;
   endproperty
   a_drive_south: assert property (p_drive_south) else $error("south drive wrong");

   property p_motor_b;
      @(posedge i_clk) disable iff (!i_rst_n)
         ctrl[SDC_BIT_MOTOR]
         |=> o_motor_select && !o_coil_ctrl_a;
   endproperty
   a_motor_b: assert property (p_motor_b) else $error("motor b not chosen");

   property p_motor_a;
      @(posedge i_clk) disable iff (!i_rst_n)
         !ctrl[SDC_BIT_MOTOR]
         |=> !o_motor_select && !o_coil_ctrl_b;
   endproperty
   a_motor_a: assert property (p_motor_a) else $error("motor a not chosen");

   property p_own;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_a
         |=> o_coil_ctrl_a && o_bridge_b == SDC_ALL_OFF;
   endproperty
   a_own: assert property (p_own) else $error("coil a not owned");

   property p_route_north;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_itg && chk_step == SDC_STEP_NORTH && ctrl[SDC_BIT_POL]
         |=> o_switch == 8'h09;
   endproperty
   a_route_north: assert property (p_route_north) else $error("north routing wrong");

   property p_route_north0;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_itg && chk_step == SDC_STEP_NORTH && !ctrl[SDC_BIT_POL]
         |=> o_switch == 8'h06;
   endproperty
   a_route_north0: assert property (p_route_north0) else $error("north routing wrong");

   property p_route_west;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_itg && chk_step == SDC_STEP_WEST && !ctrl[SDC_BIT_POL]
         |=> o_switch == 8'h60;
   endproperty
   a_route_west: assert property (p_route_west) else $error("west routing wrong");

   property p_route_south;
      @(posedge i_clk) disable iff (!i_rst_n)
         chk_itg && chk_step == SDC_STEP_SOUTH && ctrl[SDC_BIT_POL]
         |=> o_switch == 8'h06;
   endproperty
   a_route_south: assert property (p_route_south) else $error("south routing wrong");

   property p_cur_idle;
      @(posedge i_clk) disable iff (!i_rst_n)
         !chk_drv || !i_return_zero_enable
         |=> o_sin_current == SDC_I_ZERO && o_cos_current == SDC_I_ZERO;
   endproperty
   a_cur_idle: assert property (p_cur_idle) else $error("current not zero");

   property p_cur_east;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_return_zero_enable && chk_drv && chk_step == SDC_STEP_EAST
         |=> o_sin_current == SDC_I_POS && o_cos_current == SDC_I_ZERO;
   endproperty
   a_cur_east: assert property (p_cur_east) else $error("east current wrong");

   property p_cur_north;
      @(posedge i_clk) disable iff (!i_rst_n)
         i_return_zero_enable && chk_drv && chk_step == SDC_STEP_NORTH
         |=> o_cos_current == SDC_I_POS && o_sin_current == SDC_I_ZERO;
   endproperty
   a_cur_north: assert property (p_cur_north) else $error("north current wrong");

   c_integrate: cover property (@(posedge i_clk) o_switch != SDC_ALL_OFF && o_bridge_a != 8'h00);
   c_motor_b: cover property (@(posedge i_clk) o_bridge_b != 8'h00);
   c_blank: cover property (@(posedge i_clk) o_conv_reset && o_coil_ctrl_a);
endmodule

/* File: bench/sdc_motor_model.sv */
`timescale 1ns/1ns
// ==========================================================
// two-coil motor seen through its h-bridge: current sign per coil
module sdc_motor_model
   import sdc_pkg::*;
(
   input wire logic [7:0] i_bridge,
   output logic [2:0] o_sin,
   output logic [2:0] o_cos
);
   // only a diagonal pair pushes supply current; recirculation pairs give zero
   always_comb begin
      o_sin = SDC_I_ZERO;
      o_cos = SDC_I_ZERO;
      if (i_bridge[0] && i_bridge[3]) o_sin = SDC_I_POS;
      if (i_bridge[1] && i_bridge[2]) o_sin = SDC_I_NEG;
      if (i_bridge[4] && i_bridge[7]) o_cos = SDC_I_POS;
      if (i_bridge[5] && i_bridge[6]) o_cos = SDC_I_NEG;
   end
endmodule

/* File: bench/sdc_top_tb_top.sv */
`timescale 1ns/1ns
module sdc_top_tb_top;
   import sdc_pkg::*;
   logic i_clk, i_rst_n, rd, wr, en, wreq, cc_a, cc_b, msel, cres, aclr;
   logic [1:0] adr;
   logic [3:0] be;
   logic [31:0] wd, rdat, q;
   logic [7:0] br_a, br_b, sw, c;
   logic [2:0] sinc, cosc, ms, mc;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   // ==========================================================
   // clock, stimulus defaults and timeout
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      {i_rst_n, rd, wr, en, adr, be, wd} = '0;
   end
   // ceiling well above the roughly 3600 cycles the tests need
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end
   sdc_top i_sdc_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(be), .i_return_zero_enable(en), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .o_bridge_a(br_a), .o_bridge_b(br_b),
      .o_coil_ctrl_a(cc_a), .o_coil_ctrl_b(cc_b), .o_switch(sw),
      .o_motor_select(msel), .o_conv_reset(cres), .o_acc_clear(aclr),
      .o_sin_current(sinc), .o_cos_current(cosc));
   // the unselected motor bridge is all-off, so one motor model sees both
   sdc_motor_model i_sdc_motor_model (.i_bridge(br_a | br_b), .o_sin(ms), .o_cos(mc));
   // ==========================================================
   // helpers
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until the rising edge that samples waitrequest low; read data taken there
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      n = 0;
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge i_clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat;
      if (n >= 40) failures++;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   function automatic logic [7:0] exp_br(input logic [7:0] v);
      logic [7:0] dp, rp;
      case (v[1:0])
         2'h0: dp = 8'h09;
         2'h1: dp = 8'h90;
         2'h2: dp = 8'h06;
         default: dp = 8'h60;
      endcase
      rp = v[0] ? (v[5] ? 8'h0a : 8'h05) : (v[5] ? 8'ha0 : 8'h50);
      return (v[6] ? dp : 8'h00) | (v[7] ? 8'h00 : rp);
   endfunction
   function automatic logic [7:0] exp_sw(input logic [7:0] v);
      logic [63:0] t;
      t = 64'h0609_9060_0906_6090;
      return v[7] ? t[{v[1:0], v[4]} * 8 +: 8] : 8'h00;
   endfunction
   function automatic logic [2:0] cur(input logic on, input logic [1:0] s, input logic [1:0] p);
      if (!on) return 3'h1;
      return (s == p) ? 3'h2 : ((s == p + 2'h2) ? 3'h4 : 3'h1);
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // tests
   initial begin
      repeat (15) @(posedge i_clk);
      @(negedge i_clk);
      check("rst_out", {wreq, br_a, br_b, sw, cres, aclr}, {1'b1, 24'h0, 2'h3});
      check("rst_cur", {sinc, cosc}, 6'h09);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      bus(1'b0, SDC_ADDR_CTRL, 32'h0, 4'hf);
      check("rst_reg", q, 32'h0);
      $display("test reset done");
      // every control value, with the enable low then high
      for (int e = 0; e < 2; e++) begin
         for (int v = 0; v < 256; v++) begin
            c = v[7:0];
            en <= e[0];
            bus(1'b1, SDC_ADDR_CTRL, {24'ha5a5a5, c}, 4'h1);
            @(posedge i_clk);
            @(negedge i_clk);
            check("br_a", br_a, (e && !c[2]) ? exp_br(c) : 8'h00);
            check("br_b", br_b, (e && c[2]) ? exp_br(c) : 8'h00);
            check("coil", {cc_a, cc_b, msel}, {e[0] & ~c[2], e[0] & c[2], c[2]});
            check("switch", sw, exp_sw(c));
            check("conv", {cres, aclr}, {2{~c[7]}});
            check("sin", sinc, cur(e[0] & c[6], c[1:0], 2'h0));
            check("cos", cosc, cur(e[0] & c[6], c[1:0], 2'h1));
            if (e) check("model", {ms, mc}, {sinc, cosc});
            bus(1'b0, SDC_ADDR_CTRL, 32'h0, 4'hf);
            check("readback", q, {24'h0, c & SDC_CTRL_MASK});
         end
      end
      $display("test sweep done");
      // refused writes: unmapped word and lane 0 disabled
      bus(1'b1, 2'h1, 32'h0000_0055, 4'hf);
      bus(1'b1, SDC_ADDR_CTRL, 32'h0000_0011, 4'he);
      bus(1'b0, SDC_ADDR_CTRL, 32'h0, 4'hf);
      check("refused", q, 32'h0000_00f7);
      bus(1'b0, 2'h3, 32'h0, 4'hf);
      check("unmapped", q, SDC_RD_UNMAPPED);
      $display("test refuse done");
      // reset in mid-run clears the register and opens the switches
      bus(1'b1, SDC_ADDR_CTRL, 32'h0000_00d1, 4'hf);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      check("rst2", {sw, cres, br_a}, {8'h00, 1'b1, 8'h00});
      bus(1'b0, SDC_ADDR_CTRL, 32'h0, 4'hf);
      check("rst2_reg", q, 32'h0);
      $display("test midreset done");
      give_verdict();
   end
endmodule
